// [design/timer_channel_params.svh]
`ifndef TIMER_CHANNEL_PARAMS_SVH
`define TIMER_CHANNEL_PARAMS_SVH

`define TCH_NUM_CHANNELS 6
`define TCH_CNT_WIDTH 16
`define TCH_ADDR_WIDTH 8
`define TCH_CSC_BASE 8'h0C
`define TCH_CV_BASE 8'h10
`define TCH_CH_STRIDE 8'h08
`define TCH_BIT_FLAG 7
`define TCH_BIT_IRQ_EN 6
`define TCH_BIT_MODE_HI 5
`define TCH_BIT_MODE_LO 2
`define TCH_BIT_DMA_EN 0
`define TCH_MODE_RESET 4'h0
`define TCH_CV_RESET 16'h0000

`endif

// [design/timer_channel_pkg.sv]
package timer_channel_pkg;

    // Channel function, Gray coded along disabled -> compare -> capture -> PWM.
    typedef enum logic [2:0] {
        FN_OFF = 3'h0,
        FN_SWCMP = 3'h1,
        FN_CAPTURE = 3'h3,
        FN_OCMP = 3'h2,
        FN_EPWM = 3'h6,
        FN_PULSE = 3'h7,
        FN_CPWM = 3'h5
    } chan_fn_t;

endpackage

// [design/timer_channel_unit.sv]
`timescale 1ns/1ns
`include "timer_channel_params.svh"

module timer_channel_unit
    import timer_channel_pkg::*;
#(
    parameter int CNT_W = `TCH_CNT_WIDTH
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] mode_select_pair,
    input wire logic [1:0] edge_level_pair,
    input wire logic center_align_select,
    input wire logic [CNT_W-1:0] counter,
    input wire logic counter_tick,
    input wire logic counting_down,
    input wire logic counter_reload,
    input wire logic [CNT_W-1:0] channel_value,
    input wire logic pin_sync,
    output logic chan_event,
    output logic capture,
    output logic pin_out,
    output logic pin_out_en
);

    function automatic chan_fn_t decode_fn(input logic [1:0] ms, input logic [1:0] els,
                                           input logic cpwm);
        chan_fn_t fn;
        fn = FN_SWCMP;
        if (ms == 2'h0 && els == 2'h0)
            fn = FN_OFF;
        else if (els == 2'h0)
            fn = FN_SWCMP;
        else if (cpwm)
        begin
            if (ms == 2'h2)
                fn = FN_CPWM;
        end
        else
        begin
            case (ms)
                2'h0: fn = FN_CAPTURE;
                2'h1: fn = FN_OCMP;
                2'h2: fn = FN_EPWM;
                2'h3: fn = FN_PULSE;
                default: fn = FN_SWCMP;
            endcase
        end
        return fn;
    endfunction

    chan_fn_t fn;
    logic match;
    logic pin_prev_q;
    logic pin_prev_d;
    logic out_q;
    logic out_d;
    logic rise;
    logic fall;

    assign fn = decode_fn(mode_select_pair, edge_level_pair, center_align_select);
    assign match = counter_tick && (counter == channel_value);
    assign rise = pin_sync && !pin_prev_q;
    assign fall = !pin_sync && pin_prev_q;

    always_comb
    begin
        pin_prev_d = pin_sync;
        out_d = out_q;
        capture = 1'b0;
        chan_event = 1'b0;
        case (fn)
            FN_OFF:
                out_d = 1'b0;
            FN_SWCMP:
                chan_event = match;
            FN_CAPTURE:
            begin
                capture = (edge_level_pair[0] && rise) || (edge_level_pair[1] && fall);
                chan_event = capture;
            end
            FN_OCMP:
            begin
                chan_event = match;
                if (match)
                begin
                    case (edge_level_pair)
                        2'h1: out_d = !out_q;
                        2'h2: out_d = 1'b0;
                        default: out_d = 1'b1;
                    endcase
                end
            end
            FN_EPWM:
            begin
                chan_event = match;
                if (match)
                    out_d = edge_level_pair[0];
                else if (counter_reload)
                    out_d = !edge_level_pair[0];
            end
            FN_PULSE:
            begin
                chan_event = match;
                // One clock pulse at the match, idle level otherwise.
                out_d = match ? edge_level_pair[0] : !edge_level_pair[0];
            end
            FN_CPWM:
            begin
                chan_event = match;
                if (match)
                    out_d = counting_down ^ edge_level_pair[0];
            end
            default:
                out_d = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pin_prev_q <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            pin_prev_q <= pin_prev_d;
            out_q <= out_d;
        end
    end

    assign pin_out = out_q;
    assign pin_out_en = (fn == FN_OCMP) || (fn == FN_EPWM) || (fn == FN_PULSE) ||
                        (fn == FN_CPWM);

endmodule // timer_channel_unit

// [design/timer_channel_mode_control.sv]
// How it works
// - Mode and edge bits zero disable channel.
// - Nonzero mode, zero edge: software compare only.
// - Mode 00 captures rising, falling or both edges.
// - Mode 01 toggles, clears or sets on match.
// - Edge PWM high-true: low on match, high reload.
// - Edge PWM low-true: high on match, low reload.
// - Mode 11 pulses output low or high.
// - Center PWM high-true: clear up, set down.
// - Center PWM low-true: set up, clear down.
// - Channel events set flag at bit 7.
// - Writing one clears flag; zero does nothing.
// - New event before clear keeps flag set.
// - Bit 6 gates flag onto interrupt request while bit 0 is clear.
// - Mode bits read back only once acknowledged.
// - Bit 0 enables channel DMA requests.
// - Bits 31 to 8 and 1 read zero.
// - Six control registers at 0xC plus 8 each.
// - Center select picks up-down mode column.
// - Value register holds capture or match value.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "timer_channel_params.svh"

module timer_channel_mode_control
    import timer_channel_pkg::*;
#(
    parameter int NUM_CH = `TCH_NUM_CHANNELS,
    parameter int CNT_W = `TCH_CNT_WIDTH
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`TCH_ADDR_WIDTH-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [CNT_W-1:0] counter,
    input wire logic counter_tick,
    input wire logic counting_down,
    input wire logic counter_reload,
    input wire logic center_align_select,
    input wire logic [NUM_CH-1:0] chan_pin_in,
    output logic [NUM_CH-1:0] chan_pin_out,
    output logic [NUM_CH-1:0] chan_pin_oe,
    output logic [NUM_CH-1:0] chan_irq,
    output logic [NUM_CH-1:0] chan_dma_req
);

    // Returns 1 when addr is base + stride * idx for the given channel index idx.
    function automatic logic hit(input logic [`TCH_ADDR_WIDTH-1:0] addr,
                                 input logic [`TCH_ADDR_WIDTH-1:0] base,
                                 input int idx);
        logic [`TCH_ADDR_WIDTH-1:0] off;
        off = `TCH_ADDR_WIDTH'(idx * `TCH_CH_STRIDE);
        return addr == base + off;
    endfunction

    logic [NUM_CH-1:0] flag_q;
    logic [NUM_CH-1:0] flag_d;
    logic [NUM_CH-1:0] again_q;
    logic [NUM_CH-1:0] again_d;
    logic [NUM_CH-1:0] irq_en_q;
    logic [NUM_CH-1:0] irq_en_d;
    logic [NUM_CH-1:0] dma_en_q;
    logic [NUM_CH-1:0] dma_en_d;
    logic [3:0] mode_wr_q [NUM_CH];
    logic [3:0] mode_wr_d [NUM_CH];
    logic [3:0] mode_ack_q [NUM_CH];
    logic [3:0] mode_ack_d [NUM_CH];
    logic [CNT_W-1:0] value_q [NUM_CH];
    logic [CNT_W-1:0] value_d [NUM_CH];
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic center_sel_q;
    logic center_sel_d;
    logic [NUM_CH-1:0] pin_meta_q;
    logic [NUM_CH-1:0] pin_sync_q;
    logic [NUM_CH-1:0] chan_event;
    logic [NUM_CH-1:0] capture;
    logic [NUM_CH-1:0] ctrl_wr;
    logic [NUM_CH-1:0] ctrl_rd;
    logic [NUM_CH-1:0] value_wr;
    logic [NUM_CH-1:0] value_rd;

    // Pin inputs pass two flops before the channel logic looks at them.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end
        else
        begin
            pin_meta_q <= chan_pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // One unit per channel; all units share the counter inputs.
    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_chan
            timer_channel_unit #(
                .CNT_W(CNT_W)
            ) u_unit (
                .core_clk(core_clk),
                .rst(rst),
                .mode_select_pair(mode_ack_q[i][3:2]),
                .edge_level_pair(mode_ack_q[i][1:0]),
                .center_align_select(center_sel_q),
                .counter(counter),
                .counter_tick(counter_tick),
                .counting_down(counting_down),
                .counter_reload(counter_reload),
                .channel_value(value_q[i]),
                .pin_sync(pin_sync_q[i]),
                .chan_event(chan_event[i]),
                .capture(capture[i]),
                .pin_out(chan_pin_out[i]),
                .pin_out_en(chan_pin_oe[i])
            );
        end
    endgenerate

    // Register strobes decoded once per channel for every group below.
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            ctrl_wr[i] = reg_wr && hit(reg_addr, `TCH_CSC_BASE, i);
            ctrl_rd[i] = reg_rd && hit(reg_addr, `TCH_CSC_BASE, i);
            value_wr[i] = reg_wr && hit(reg_addr, `TCH_CV_BASE, i);
            value_rd[i] = reg_rd && hit(reg_addr, `TCH_CV_BASE, i);
        end
    end

    // Interrupt and DMA enables follow every control write.
    always_comb
    begin
        irq_en_d = irq_en_q;
        dma_en_d = dma_en_q;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (ctrl_wr[i])
            begin
                irq_en_d[i] = reg_wdata[`TCH_BIT_IRQ_EN];
                dma_en_d[i] = reg_wdata[`TCH_BIT_DMA_EN];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_en_q <= '0;
            dma_en_q <= '0;
        end
        else
        begin
            irq_en_q <= irq_en_d;
            dma_en_q <= dma_en_d;
        end
    end

    // Event flags: a hardware set wins over a clear in the same cycle.
    always_comb
    begin
        flag_d = flag_q;
        again_d = again_q;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (ctrl_wr[i] && reg_wdata[`TCH_BIT_FLAG])
            begin
                // A clear attempt after a second event is dropped once.
                if (!again_q[i])
                    flag_d[i] = 1'b0;
                again_d[i] = 1'b0;
            end
            if (chan_event[i])
            begin
                if (flag_q[i])
                    again_d[i] = 1'b1;
                flag_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            flag_q <= '0;
            again_q <= '0;
        end
        else
        begin
            flag_q <= flag_d;
            again_q <= again_d;
        end
    end

    // The center-align select is registered once before the channels use it.
    always_comb
    begin
        center_sel_d = center_align_select;
        for (int i = 0; i < NUM_CH; i++)
        begin
            mode_wr_d[i] = mode_wr_q[i];
            // The staged mode is taken over by the counter side one cycle later;
            // software must pass through disabled first.
            mode_ack_d[i] = mode_wr_q[i];
            if (ctrl_wr[i])
                mode_wr_d[i] = reg_wdata[`TCH_BIT_MODE_HI:`TCH_BIT_MODE_LO];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            center_sel_q <= 1'b0;
        else
            center_sel_q <= center_sel_d;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (rst)
            begin
                mode_wr_q[i] <= `TCH_MODE_RESET;
                mode_ack_q[i] <= `TCH_MODE_RESET;
            end
            else
            begin
                mode_wr_q[i] <= mode_wr_d[i];
                mode_ack_q[i] <= mode_ack_d[i];
            end
        end
    end

    // Value writes are ignored while the channel is disabled or capturing.
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            value_d[i] = value_q[i];
            if (value_wr[i] && mode_ack_q[i] != 4'h0 && mode_ack_q[i][3:2] != 2'h0)
                value_d[i] = reg_wdata[CNT_W-1:0];
            // A capture wins over a software write in the same cycle.
            if (capture[i])
                value_d[i] = counter;
        end
    end

    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (rst)
                value_q[i] <= `TCH_CV_RESET;
            else
                value_q[i] <= value_d[i];
        end
    end

    // Read data stand in the cycle after the strobe and are zero otherwise.
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (ctrl_rd[i])
            begin
                rdata_d[`TCH_BIT_FLAG] = flag_q[i];
                rdata_d[`TCH_BIT_IRQ_EN] = irq_en_q[i];
                rdata_d[`TCH_BIT_MODE_HI:`TCH_BIT_MODE_LO] = mode_ack_q[i];
                rdata_d[`TCH_BIT_DMA_EN] = dma_en_q[i];
            end
            // Value registers read back in the low half; the upper bits stay zero.
            if (value_rd[i])
                rdata_d[CNT_W-1:0] = value_q[i];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata_q <= 32'h0000_0000;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;
    // A DMA request takes the place of the interrupt for the same event.
    assign chan_dma_req = flag_q & dma_en_q;
    assign chan_irq = flag_q & irq_en_q & ~dma_en_q;

endmodule // timer_channel_mode_control

// [tb/timer_channel_mode_control_properties.sv]
`timescale 1ns/1ns
module timer_channel_mode_control_properties
#(
    parameter int NUM_CH = 6,
    parameter int CNT_W = 16
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [CNT_W-1:0] counter,
    input wire logic counter_tick,
    input wire logic counting_down,
    input wire logic counter_reload,
    input wire logic center_align_select,
    input wire logic [NUM_CH-1:0] chan_pin_in,
    input wire logic [NUM_CH-1:0] chan_pin_out,
    input wire logic [NUM_CH-1:0] chan_pin_oe,
    input wire logic [NUM_CH-1:0] chan_irq,
    input wire logic [NUM_CH-1:0] chan_dma_req
);
    // Channel 0 mode as the channel logic uses it, two edges after the write.
    logic wr0;
    logic [3:0] m1_q;
    logic [3:0] m1_d;
    logic [3:0] m2_q;
    logic ca_q;
    assign wr0 = reg_wr && reg_addr == 8'h0C;
    always_comb m1_d = wr0 ? reg_wdata[5:2] : m1_q;
    always_ff @(posedge core_clk)
    begin
        m1_q <= rst ? 4'h0 : m1_d;
        m2_q <= rst ? 4'h0 : m1_q;
        ca_q <= rst ? 1'b0 : center_align_select;
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    a_rsv_zero: assert property (
        s_rd(8'h0C) |=> !reg_rdata[1] && reg_rdata[31:8] == 24'h0)
        else $error("reserved bits nonzero");
    a_unmapped_zero: assert property (s_rd(8'h3C) |=> reg_rdata == 32'h0)
        else $error("unmapped read nonzero");
    a_irq_mask: assert property (
        wr0 && !reg_wdata[6] && !reg_wdata[0] |=> !chan_irq[0] && !chan_dma_req[0])
        else $error("request while disabled");
    a_dma_excl: assert property ((chan_irq & chan_dma_req) == '0)
        else $error("irq and dma together");
    a_dma_gate: assert property (
        wr0 && reg_wdata[0] && !reg_wdata[7] && chan_irq[0] |=> chan_dma_req[0] && !chan_irq[0])
        else $error("dma enable ignored");
    a_off_no_oe: assert property (m2_q[1:0] == 2'b00 |-> !chan_pin_oe[0])
        else $error("pin driven in compare-only mode");
    a_ocmp_oe: assert property (m2_q == 4'b0111 && !ca_q |-> chan_pin_oe[0])
        else $error("pin not driven");
    a_epwm_reload: assert property (
        counter_reload && m2_q == 4'hA && !ca_q |=> chan_pin_out[0])
        else $error("reload did not set output");
endmodule // timer_channel_mode_control_properties

bind timer_channel_mode_control timer_channel_mode_control_properties
    #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) props (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .counter, .counter_tick, .counting_down, .counter_reload,
    .center_align_select, .chan_pin_in, .chan_pin_out, .chan_pin_oe, .chan_irq, .chan_dma_req);

// [tb/test_timer_channel_mode_control.sv]
`timescale 1ns/1ns
module test_timer_channel_mode_control;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic counter_tick = 1'b0, counting_down = 1'b0, counter_reload = 1'b0;
    logic center_align_select = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
    logic [15:0] counter = 16'h0;
    logic [5:0] chan_pin_in = 6'h0, chan_pin_out, chan_pin_oe, chan_irq, chan_dma_req;
    int n_fail = 0, cmp_count = 0;
    // Rows: address, write data, expected read back.
    logic [7:0] ta [6] = '{8'h0C, 8'h14, 8'h34, 8'h38, 8'h3C, 8'h50};
    logic [31:0] tw [6] = '{32'hFFFF_FF7F, 32'h41, 32'h2C, 32'h1_1234, 32'hFFFF_FFFF, 32'h1};
    logic [31:0] te [6] = '{32'h7D, 32'h41, 32'h2C, 32'h0, 32'h0, 32'h0};

    timer_channel_mode_control DUT (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .counter, .counter_tick, .counting_down, .counter_reload,
        .center_align_select, .chan_pin_in, .chan_pin_out, .chan_pin_oe, .chan_irq,
        .chan_dma_req);

    always #50 core_clk = ~core_clk;

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    // One counter tick (or reload) with the given value, then time to settle.
    task automatic ev(logic [15:0] c, logic dn, logic rl);
        @(posedge core_clk);
        counter <= c;
        counting_down <= dn;
        counter_tick <= !rl;
        counter_reload <= rl;
        @(posedge core_clk);
        counter_tick <= 1'b0;
        counter_reload <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        n_fail++;
        close_out();
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h0C);
        chk(rv, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(ta[i], tw[i]);
            rd(ta[i]);
            chk(rv, te[i]);
            wr(ta[i], 32'h0);
        end
        wr(8'h0C, 32'h5C);
        wr(8'h10, 32'h10);
        ev(16'h0010, 1'b0, 1'b0);
        chk({29'h0, chan_pin_oe[0], chan_pin_out[0], chan_irq[0]}, 32'h7);
        rd(8'h0C);
        chk(rv, 32'hDC);
        wr(8'h0C, 32'h5C);
        rd(8'h0C);
        chk(rv, 32'hDC);
        ev(16'h0010, 1'b0, 1'b0);
        wr(8'h0C, 32'hDC);
        rd(8'h0C);
        chk(rv, 32'hDC);
        wr(8'h0C, 32'hDC);
        rd(8'h0C);
        chk(rv, 32'h5C);
        ev(16'h0010, 1'b0, 1'b0);
        wr(8'h0C, 32'h5D);
        #1;
        chk({30'h0, chan_dma_req[0], chan_irq[0]}, 32'h2);
        wr(8'h0C, 32'h80);
        rd(8'h0C);
        chk(rv, 32'h0);
        chk({31'h0, chan_pin_oe[0]}, 32'h0);
        for (int j = 0; j < 3; j++)
        begin
            wr(8'h0C, (j == 0) ? 32'h28 : (j == 1) ? 32'h2C : 32'h24);
            wr(8'h10, 32'h4);
            ev(16'h0004, 1'b0, 1'b0);
            chk({31'h0, chan_pin_out[0]}, 32'(j != 0));
            ev(16'h0000, 1'b0, 1'b1);
            chk({31'h0, chan_pin_out[0]}, 32'(j == 0));
            wr(8'h0C, 32'h0);
        end
        wr(8'h0C, 32'h38);
        wr(8'h10, 32'h8);
        #1;
        chk({31'h0, chan_pin_out[0]}, 32'h1);
        @(posedge core_clk);
        counter <= 16'h0008;
        counter_tick <= 1'b1;
        @(posedge core_clk);
        counter_tick <= 1'b0;
        #1;
        chk({31'h0, chan_pin_out[0]}, 32'h0);
        @(posedge core_clk);
        #1;
        chk({31'h0, chan_pin_out[0]}, 32'h1);
        wr(8'h0C, 32'h0);
        wr(8'h0C, 32'h14);
        ev(16'h0008, 1'b0, 1'b0);
        chk({31'h0, chan_pin_out[0]}, 32'h1);
        ev(16'h0008, 1'b0, 1'b0);
        chk({31'h0, chan_pin_out[0]}, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h1C, 32'h04);
        @(posedge core_clk);
        counter <= 16'h0077;
        chan_pin_in <= 6'h04;
        repeat (6) @(posedge core_clk);
        rd(8'h20);
        chk(rv, 32'h77);
        rd(8'h1C);
        chk(rv, 32'h84);
        @(posedge core_clk);
        center_align_select <= 1'b1;
        wr(8'h24, 32'h28);
        wr(8'h28, 32'h5);
        ev(16'h0005, 1'b1, 1'b0);
        chk({31'h0, chan_pin_out[3]}, 32'h1);
        ev(16'h0005, 1'b0, 1'b0);
        chk({31'h0, chan_pin_out[3]}, 32'h0);
        wr(8'h24, 32'h0);
        wr(8'h24, 32'h2C);
        ev(16'h0005, 1'b0, 1'b0);
        chk({31'h0, chan_pin_out[3]}, 32'h1);
        ev(16'h0005, 1'b1, 1'b0);
        chk({31'h0, chan_pin_out[3]}, 32'h0);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h1C);
        chk(rv, 32'h0);
        chk({20'h0, chan_pin_out, chan_pin_oe}, 32'h0);
        chk({20'h0, chan_irq, chan_dma_req}, 32'h0);
        close_out();
    end
endmodule // test_timer_channel_mode_control
